// File: rtl/buck_seq_pkg.sv
package buck_seq_pkg;

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   localparam int CLK_KHZ = 50000;   // 50 MHz core clock
   localparam int TMR_W = 22;        // Width of every interval timer

   // ----------------------------------------
   // Intervals in their own units
   // ----------------------------------------
   localparam int HICCUP_SLEEP_MS = 56;
   localparam int PG_DELAY_MS = 1;
   localparam int UV_DELAY_US = 16;

   // ----------------------------------------
   // Intervals in core clock cycles
   // ----------------------------------------
   localparam logic [TMR_W-1:0] HICCUP_CYCLES =
      TMR_W'(HICCUP_SLEEP_MS * CLK_KHZ);
   localparam logic [TMR_W-1:0] PG_DELAY_CYCLES =
      TMR_W'(PG_DELAY_MS * CLK_KHZ);
   localparam logic [TMR_W-1:0] UV_DELAY_CYCLES =
      TMR_W'((UV_DELAY_US * CLK_KHZ + 999) / 1000);

   // ----------------------------------------
   // Comparator thresholds, applied outside
   // ----------------------------------------
   localparam int OV_THRESH_MV = 950;
   localparam int UV_THRESH_MV = 600;
   localparam int NEG_LIMIT_A = -16;
   localparam int OT_RISE_C = 166;
   localparam int OT_HYST_C = 30;
   localparam int VIN_OV_MV = 18600;

   // ----------------------------------------
   // On-time counter
   // ----------------------------------------
   localparam int TON_W = 8;
   localparam logic [TON_W-1:0] TON_MIN = 8'h01;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,  // Off, waiting for enable and supplies
      ST_SOFTSTART = 4'h1,  // Switching, ramp in progress
      ST_RUN       = 4'h2,  // Normal regulation
      ST_OV_LS     = 4'h3,  // Discharge, low side on
      ST_OV_HS     = 4'h4,  // Discharge, high side on-time
      ST_OV_HOLD   = 4'h5,  // Discharged, low side held on
      ST_LATCH_OFF = 4'h6,  // Both switches latched off
      ST_HICCUP    = 4'h7,  // Both off, sleep before retry
      ST_OT_WAIT   = 4'h8,  // Power stage hot, waiting to cool
      ST_VIN_LATCH = 4'h9   // Input overvoltage latch
   } seq_state_t;

endpackage

// File: rtl/interval_timer.sv
`timescale 1ns/1ps
`default_nettype none

module interval_timer
   import buck_seq_pkg::*;
#(
   parameter int W = TMR_W
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic clear,
   input wire logic run,
   input wire logic [W-1:0] limit,
   // Status
   output logic expired
);

   logic [W-1:0] cnt_r;   // Cycles counted so far
   logic expired_r;       // Limit reached, sticky until clear

   // ----------------------------------------
   // Counter
   // ----------------------------------------
   // Counts while run is high, stops at the limit
   always_ff @(posedge core_clk)
   begin
      if (rst || clear)
      begin
         cnt_r <= '0;
         expired_r <= 1'b0;
      end
      else if (run && !expired_r)
      begin
         if (cnt_r >= limit - W'(1))
            expired_r <= 1'b1;
         else
            cnt_r <= cnt_r + W'(1);
      end
   end

   assign expired = expired_r;

endmodule // interval_timer

`default_nettype wire

// File: rtl/buck_fault_pgood_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module buck_fault_pgood_sequencer
   import buck_seq_pkg::*;
#(
   parameter logic [TMR_W-1:0] HICCUP_LIMIT = HICCUP_CYCLES,
   parameter logic [TMR_W-1:0] PG_LIMIT = PG_DELAY_CYCLES
)
(
   // Clock and bias-supply reset
   input wire logic core_clk,
   input wire logic rst,
   // Enable and supplies
   input wire logic enable_in,
   input wire logic power_input_rail_ok,
   input wire logic driver_bias_rail_ok,
   input wire logic split_rail_cfg,
   // Straps
   input wire logic strap_hiccup,
   input wire logic strap_skip,
   // Comparator flags
   input wire logic output_overvoltage_cmp,
   input wire logic output_undervoltage_cmp,
   input wire logic output_in_window,
   input wire logic negative_current_limit,
   input wire logic zero_cross_detect,
   input wire logic output_discharged,
   input wire logic power_stage_die_hot,
   input wire logic controller_die_hot,
   input wire logic power_input_rail_ov,
   // Loop interface
   input wire logic soft_start_done,
   input wire logic loop_on_request,
   input wire logic [TON_W-1:0] on_time_cycles,
   // Switch controls
   output logic high_side_on,
   output logic low_side_on,
   // Power-good open-drain pin
   output logic power_good_out,
   output logic power_good_oe_n,
   // Status
   output logic soft_start_active,
   output logic fault_latched,
   output logic forced_continuous_mode,
   output logic discontinuous_skip_mode
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   seq_state_t state_r, state_nxt;   // Sequencer state
   logic hs_r, hs_nxt;               // High-side switch
   logic ls_r, ls_nxt;               // Low-side switch
   logic [TON_W-1:0] ton_r, ton_nxt; // On-time left
   logic strap_taken_r;              // Straps captured
   logic hiccup_sel_r;               // Hiccup response chosen
   logic skip_sel_r;                 // Skip mode chosen
   logic pg_low_r;                   // Power-good pulled low
   logic latched_r;                  // Latched fault status
   logic ss_r;                       // Soft-start running
   logic enable_d_r;                 // Enable, previous cycle
   logic enable_fall;                // Enable deasserted edge
   logic supplies_ok;                // Supplies allow switching
   logic start_ok;                   // All start conditions met
   logic hiccup_run;                 // Sleep timer running
   logic hiccup_done;                // Sleep interval elapsed
   logic uv_run;                     // Undervoltage persisting
   logic uv_done;                    // Undervoltage qualified
   logic pg_run;                     // Power-good delay running
   logic pg_done;                    // Power-good delay elapsed
   logic [TON_W-1:0] ton_load;       // On-time to load

   // ----------------------------------------
   // Strap capture
   // ----------------------------------------
   // First cycle after reset only; enable does not resample
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         strap_taken_r <= 1'b0;
         hiccup_sel_r <= 1'b0;
         skip_sel_r <= 1'b0;
      end
      else if (!strap_taken_r)
      begin
         strap_taken_r <= 1'b1;
         hiccup_sel_r <= strap_hiccup;
         skip_sel_r <= strap_skip;
      end
   end

   // ----------------------------------------
   // Enable edge and start conditions
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         enable_d_r <= 1'b0;
      else
         enable_d_r <= enable_in;
   end

   assign enable_fall = enable_d_r && !enable_in;

   // Level checks only, so arrival order does not matter
   assign supplies_ok = power_input_rail_ok &&
      (!split_rail_cfg || driver_bias_rail_ok);
   assign start_ok = strap_taken_r && enable_in && supplies_ok;

   // Zero on-time would stall the pulse; use one cycle
   assign ton_load = (on_time_cycles < TON_MIN) ? TON_MIN :
      on_time_cycles;

   // ----------------------------------------
   // Timers
   // ----------------------------------------
   // Sleep runs from the fault trigger through discharge
   assign hiccup_run = hiccup_sel_r &&
      (state_r == ST_OV_LS || state_r == ST_OV_HS ||
       state_r == ST_OV_HOLD || state_r == ST_HICCUP);

   interval_timer #(.W(TMR_W)) u_hiccup_timer
   (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!hiccup_run || enable_fall),
      .run(hiccup_run),
      .limit(HICCUP_LIMIT),
      .expired(hiccup_done)
   );

   // Any return above threshold restarts the delay at zero
   assign uv_run = (state_r == ST_RUN) && output_undervoltage_cmp;

   interval_timer #(.W(TMR_W)) u_uv_timer
   (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!uv_run || enable_fall),
      .run(uv_run),
      .limit(UV_DELAY_CYCLES),
      .expired(uv_done)
   );

   // Delay counts only after soft-start has finished
   assign pg_run = (state_r == ST_RUN);

   interval_timer #(.W(TMR_W)) u_pg_timer
   (
      .core_clk(core_clk),
      .rst(rst),
      .clear(!pg_run || enable_fall),
      .run(pg_run),
      .limit(PG_LIMIT),
      .expired(pg_done)
   );

   // ----------------------------------------
   // Next state and switch drive
   // ----------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      hs_nxt = hs_r;
      ls_nxt = ls_r;
      ton_nxt = ton_r;
      case (state_r)
         ST_IDLE:
         begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
            if (start_ok)
               state_nxt = ST_SOFTSTART;
         end
         ST_SOFTSTART, ST_RUN:
         begin
            // Regular pulse train from the loop
            if (hs_r)
            begin
               if (ton_r <= TON_MIN)
               begin
                  hs_nxt = 1'b0;
                  ls_nxt = 1'b1;
               end
               else
                  ton_nxt = ton_r - TON_MIN;
            end
            else if (loop_on_request)
            begin
               // Same on-time in either mode
               hs_nxt = 1'b1;
               ls_nxt = 1'b0;
               ton_nxt = ton_load;
            end
            else if (ls_r && skip_sel_r && zero_cross_detect)
               ls_nxt = 1'b0;
            // Forced mode leaves low side on until next pulse
            if (state_r == ST_SOFTSTART && soft_start_done)
               state_nxt = ST_RUN;
            // Faults, highest priority last
            if (controller_die_hot)
            begin
               hs_nxt = 1'b0;
               ls_nxt = 1'b0;
               state_nxt = hiccup_sel_r ? ST_HICCUP :
                  ST_LATCH_OFF;
            end
            if (state_r == ST_RUN && uv_done)
            begin
               hs_nxt = 1'b0;
               ls_nxt = 1'b0;
               state_nxt = hiccup_sel_r ? ST_HICCUP :
                  ST_LATCH_OFF;
            end
            if (state_r == ST_RUN && output_overvoltage_cmp)
            begin
               // Comparator looked at only after ramp
               hs_nxt = 1'b0;
               ls_nxt = 1'b1;
               state_nxt = ST_OV_LS;
            end
            if (power_stage_die_hot)
            begin
               hs_nxt = 1'b0;
               ls_nxt = 1'b0;
               state_nxt = ST_OT_WAIT;
            end
            if (power_input_rail_ov)
            begin
               hs_nxt = 1'b0;
               ls_nxt = 1'b0;
               state_nxt = ST_VIN_LATCH;
            end
         end
         ST_OV_LS:
         begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b1;
            if (output_discharged)
               state_nxt = ST_OV_HOLD;
            else if (negative_current_limit)
            begin
               hs_nxt = 1'b1;
               ls_nxt = 1'b0;
               ton_nxt = ton_load;
               state_nxt = ST_OV_HS;
            end
         end
         ST_OV_HS:
         begin
            if (ton_r <= TON_MIN)
            begin
               // Back to low side for another cycle
               hs_nxt = 1'b0;
               ls_nxt = 1'b1;
               state_nxt = ST_OV_LS;
            end
            else
               ton_nxt = ton_r - TON_MIN;
         end
         ST_OV_HOLD:
         begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b1;
            // Latch-off stays here; hiccup retries on sleep end
            if (hiccup_sel_r && hiccup_done)
               state_nxt = ST_IDLE;
         end
         ST_LATCH_OFF, ST_VIN_LATCH:
         begin
            // Left only by reset, enable drop or supply drop
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
         end
         ST_HICCUP:
         begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
            if (hiccup_done)
               state_nxt = ST_IDLE;
         end
         ST_OT_WAIT:
         begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
            // Flag carries the hysteresis; retry from soft-start
            if (!power_stage_die_hot)
               state_nxt = ST_IDLE;
         end
         default:
         begin
            hs_nxt = 1'b0;
            ls_nxt = 1'b0;
            state_nxt = ST_IDLE;
         end
      endcase
      // Disable by enable or supplies overrides everything
      if (!enable_in || !supplies_ok || enable_fall)
      begin
         hs_nxt = 1'b0;
         ls_nxt = 1'b0;
         state_nxt = ST_IDLE;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
         state_r <= ST_IDLE;
      else
         state_r <= state_nxt;
   end

   // ----------------------------------------
   // Switch and on-time registers
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         hs_r <= 1'b0;
         ls_r <= 1'b0;
         ton_r <= '0;
      end
      else
      begin
         hs_r <= hs_nxt;
         ls_r <= ls_nxt;
         ton_r <= ton_nxt;
      end
   end

   // ----------------------------------------
   // Power-good
   // ----------------------------------------
   // Pulled low unless running, delayed and inside window
   always_ff @(posedge core_clk)
   begin
      if (rst)
         pg_low_r <= 1'b1;
      else if (state_nxt != ST_RUN || !enable_in || !supplies_ok)
         pg_low_r <= 1'b1;
      else
         pg_low_r <= !(pg_done && output_in_window);
   end

   // ----------------------------------------
   // Status registers
   // ----------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         ss_r <= 1'b0;
         latched_r <= 1'b0;
      end
      else
      begin
         ss_r <= (state_nxt == ST_SOFTSTART);
         latched_r <= (state_nxt == ST_LATCH_OFF) ||
            (state_nxt == ST_VIN_LATCH) ||
            (state_nxt == ST_OV_HOLD && !hiccup_sel_r);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign high_side_on = hs_r;
   assign low_side_on = ls_r;
   assign power_good_out = 1'b0;
   assign power_good_oe_n = !pg_low_r;
   assign soft_start_active = ss_r;
   assign fault_latched = latched_r;
   assign forced_continuous_mode = strap_taken_r && !skip_sel_r;
   assign discontinuous_skip_mode = strap_taken_r && skip_sel_r;

endmodule // buck_fault_pgood_sequencer

`default_nettype wire

// File: testbench/buck_seq_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------
// Port checker
// ------------------------
module buck_seq_props
   import buck_seq_pkg::*;
#(
   parameter logic [TMR_W-1:0] PG_LIMIT = PG_DELAY_CYCLES
)
(
   // Clock, reset, supplies
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable_in,
   input wire logic power_input_rail_ok,
   input wire logic driver_bias_rail_ok,
   input wire logic split_rail_cfg,
   // Straps and flags
   input wire logic strap_skip,
   input wire logic output_in_window,
   input wire logic zero_cross_detect,
   input wire logic power_stage_die_hot,
   input wire logic controller_die_hot,
   input wire logic power_input_rail_ov,
   input wire logic soft_start_done,
   input wire logic loop_on_request,
   // Outputs watched
   input wire logic high_side_on,
   input wire logic low_side_on,
   input wire logic power_good_out,
   input wire logic power_good_oe_n,
   input wire logic soft_start_active,
   input wire logic fault_latched,
   input wire logic forced_continuous_mode,
   input wire logic discontinuous_skip_mode
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Enable and supplies all good
   wire logic sup_ok = enable_in && power_input_rail_ok
      && (!split_rail_cfg || driver_bias_rail_ok);
   // Soft-start with no cause to leave it
   wire logic ss_calm = soft_start_active && sup_ok && !soft_start_done
      && !power_stage_die_hot && !controller_die_hot && !power_input_rail_ov;
   logic [TMR_W-1:0] calm_r; // Cycles since soft-start
   // Count time since soft-start ended
   always_ff @(posedge core_clk)
   begin
      if (rst || soft_start_active)
         calm_r <= '0;
      else if (calm_r != '1)
         calm_r <= calm_r + TMR_W'(1);
   end
   // Second edge after reset release
   sequence straps_taken_s;
      $fell(rst) ##1 1'b1;
   endsequence
   // One mode, kept steady
   sequence mode_fixed_s;
      (forced_continuous_mode != discontinuous_skip_mode)
         ##1 $stable({forced_continuous_mode, discontinuous_skip_mode});
   endsequence
   AST_PG_OFF: assert property ((!enable_in || !power_input_rail_ok) |=> !power_good_oe_n)
      else $error("power-good released while disabled");
   AST_PG_WIN: assert property (!output_in_window |=> !power_good_oe_n)
      else $error("power-good released outside window");
   AST_PG_PIN: assert property (power_good_out == 1'b0)
      else $error("power-good pin data not low");
   AST_PG_DLY: assert property ($rose(power_good_oe_n) |-> calm_r >= PG_LIMIT)
      else $error("power-good released before its delay");
   AST_PS_HOT: assert property (power_stage_die_hot && soft_start_active
      && !soft_start_done |=> !high_side_on && !low_side_on)
      else $error("switching while stage hot");
   AST_CTRL_HOT: assert property (controller_die_hot && soft_start_active
      && !soft_start_done |=> !high_side_on && !low_side_on)
      else $error("switching while controller hot");
   AST_VIN_OV: assert property (power_input_rail_ov && soft_start_active
      && sup_ok |=> fault_latched && !high_side_on && !low_side_on)
      else $error("input overvoltage not latched off");
   AST_OV_IGN: assert property (ss_calm |=> soft_start_active)
      else $error("soft-start left without cause");
   AST_SKIP_ZC: assert property (discontinuous_skip_mode && ss_calm
      && low_side_on && zero_cross_detect |=> !low_side_on)
      else $error("low side kept on past zero current");
   AST_FORCED_CONTINUOUS_MODE_LS: assert property (forced_continuous_mode && ss_calm
      && low_side_on && !loop_on_request |=> low_side_on)
      else $error("low side dropped in forced mode");
   AST_STRAP: assert property (straps_taken_s |-> forced_continuous_mode
      == !$past(strap_skip))
      else $error("mode strap not taken");
   AST_MODE_HOLD: assert property ((forced_continuous_mode
      || discontinuous_skip_mode) |-> mode_fixed_s)
      else $error("mode changed after strap capture");
endmodule // buck_seq_props

bind buck_fault_pgood_sequencer buck_seq_props #(.PG_LIMIT(PG_LIMIT)) u_props (
   .core_clk, .rst, .enable_in, .power_input_rail_ok, .driver_bias_rail_ok,
   .split_rail_cfg, .strap_skip, .output_in_window, .zero_cross_detect,
   .power_stage_die_hot, .controller_die_hot, .power_input_rail_ov,
   .soft_start_done, .loop_on_request, .high_side_on, .low_side_on,
   .power_good_out, .power_good_oe_n, .soft_start_active, .fault_latched,
   .forced_continuous_mode, .discontinuous_skip_mode
);
`default_nettype wire

// File: testbench/buck_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------
// Power stage and sensing
// ------------------------
module buck_stage_model
#(
   parameter int NEG_DLY = 3, // Low-side cycles to sink limit
   parameter int ZC_DLY = 2, // Low-side cycles to zero current
   parameter int DONE_HS = 4 // High-side cycles to discharge
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Switch commands
   input wire logic high_side_on,
   input wire logic low_side_on,
   // Overvoltage event under way
   input wire logic discharge_en,
   // Sensed flags
   output logic negative_current_limit,
   output logic zero_cross_detect,
   output logic output_discharged
);
   int ls_cnt_r; // Low-side on time
   int hs_cnt_r; // High-side time while discharging
   // Count switch on-times
   always_ff @(posedge core_clk)
   begin
      ls_cnt_r <= (rst || !low_side_on) ? 0 : ls_cnt_r + 1;
      hs_cnt_r <= (rst || !discharge_en) ? 0 : hs_cnt_r + int'(high_side_on);
   end
   // Current goes negative while sinking
   assign negative_current_limit = discharge_en && !output_discharged
      && low_side_on && ls_cnt_r >= NEG_DLY;
   // Light load: zero current each low-side phase
   assign zero_cross_detect = low_side_on && ls_cnt_r >= ZC_DLY;
   // Enough energy returned to the input
   assign output_discharged = discharge_en && hs_cnt_r >= DONE_HS;
endmodule // buck_stage_model
`default_nettype wire

// File: testbench/buck_fault_pgood_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module buck_fault_pgood_sequencer_tb;
   import buck_seq_pkg::*;
   localparam logic [TMR_W-1:0] HIC = 22'h32; // Short hiccup sleep
   localparam logic [TMR_W-1:0] PGL = 22'h14; // Short power-good delay
   localparam int HI = 50; // Same figures as integers
   localparam int PG = 20;
   localparam int UV = int'(UV_DELAY_CYCLES);
   // ------------------------
   // Stimulus and results
   // ------------------------
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic enable_in = 1'b0;
   logic power_input_rail_ok = 1'b0;
   logic driver_bias_rail_ok = 1'b0;
   logic split_rail_cfg = 1'b0;
   logic strap_hiccup = 1'b0;
   logic strap_skip = 1'b0;
   logic output_overvoltage_cmp = 1'b0;
   logic output_undervoltage_cmp = 1'b0;
   logic output_in_window = 1'b1;
   logic power_stage_die_hot = 1'b0;
   logic controller_die_hot = 1'b0;
   logic power_input_rail_ov = 1'b0;
   logic soft_start_done = 1'b0;
   logic loop_on_request = 1'b0;
   logic [TON_W-1:0] on_time_cycles = 8'h01;
   logic discharge_en = 1'b0;
   logic negative_current_limit, zero_cross_detect, output_discharged;
   logic high_side_on, low_side_on, power_good_out, power_good_oe_n;
   logic soft_start_active, fault_latched, forced_continuous_mode;
   logic discontinuous_skip_mode;
   int error_cnt = 0;
   int n_checks = 0;
   int seed = 32'h4c44;
   int hs_len = 0; // Cycles of current high-side pulse
   int exp_w = 1; // Model on-time of that pulse
   int k, n;
   always #10 core_clk = ~core_clk;
   buck_fault_pgood_sequencer #(.HICCUP_LIMIT(HIC), .PG_LIMIT(PGL)) DUT (
      .core_clk, .rst, .enable_in, .power_input_rail_ok, .driver_bias_rail_ok,
      .split_rail_cfg, .strap_hiccup, .strap_skip, .output_overvoltage_cmp,
      .output_undervoltage_cmp, .output_in_window, .negative_current_limit,
      .zero_cross_detect, .output_discharged, .power_stage_die_hot,
      .controller_die_hot, .power_input_rail_ov, .soft_start_done,
      .loop_on_request, .on_time_cycles, .high_side_on, .low_side_on,
      .power_good_out, .power_good_oe_n, .soft_start_active, .fault_latched,
      .forced_continuous_mode, .discontinuous_skip_mode);
   buck_stage_model u_stage (.core_clk, .rst, .high_side_on, .low_side_on,
      .discharge_en, .negative_current_limit, .zero_cross_detect,
      .output_discharged);
   // ------------------------
   // Compare and wait helpers
   // ------------------------
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi);
      n_checks++;
      if (got < lo || got > hi)
      begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, lo);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge core_clk);
   endtask
   // Wait for soft-start, power-good or discharge
   task automatic wait_hi(input int sel, input int lim, output int w);
      w = 0;
      while (w < lim && (sel == 0 ? soft_start_active : sel == 1 ?
         power_good_oe_n : output_discharged) !== 1'b1)
      begin
         cyc(1);
         w++;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Model on-time of every high-side pulse
   always @(negedge core_clk)
   begin
      if (rst)
         hs_len = 0;
      else if (high_side_on === 1'b1)
      begin
         if (hs_len == 0)
            exp_w = (on_time_cycles == 0) ? 1 : int'(on_time_cycles);
         hs_len++;
      end
      else if (hs_len > 0)
      begin
         chk_cnt(hs_len, exp_w, exp_w);
         hs_len = 0;
      end
   end
   // ------------------------
   // Scenario steps
   // ------------------------
   task automatic pulse(input logic skip);
      on_time_cycles = TON_W'($random(seed) & 7);
      loop_on_request = 1'b1;
      cyc(1);
      loop_on_request = 1'b0;
      cyc(14);
      chk_bit(low_side_on, !skip);
   endtask
   task automatic recover(input logic tog);
      if (tog)
      begin
         enable_in = 1'b0;
         cyc(2);
         enable_in = 1'b1;
      end
      wait_hi(0, 400, n);
      chk_bit(soft_start_active, 1'b1);
   endtask
   task automatic ov_case(input logic hc);
      on_time_cycles = TON_W'($random(seed) & 3);
      discharge_en = 1'b1;
      output_overvoltage_cmp = 1'b1;
      cyc(1);
      chk_bit(low_side_on & !high_side_on, 1'b1);
      wait_hi(2, 40, n);
      output_overvoltage_cmp = 1'b0;
      cyc(2);
      k = n + 3;
      chk_bit(low_side_on & !high_side_on, 1'b1);
      if (hc)
      begin
         wait_hi(0, HI + 20, n);
         chk_cnt(k + n, HI, HI + 6);
      end
      else
      begin
         cyc(HI + 10);
         chk_bit(fault_latched & low_side_on, 1'b1);
         recover(1'b1);
      end
      discharge_en = 1'b0;
   endtask
   initial
   begin
      for (int p = 0; p < 4; p++)
      begin
         rst = 1'b1;
         enable_in = 1'b0;
         power_input_rail_ok = 1'b0;
         split_rail_cfg = (p == 3);
         strap_skip = p[0];
         strap_hiccup = p[1];
         soft_start_done = 1'b0;
         cyc(8);
         chk_bit(power_good_oe_n | high_side_on | low_side_on, 1'b0);
         rst = 1'b0;
         cyc(2);
         chk_bit(discontinuous_skip_mode, p[0]);
         strap_skip = !p[0];
         driver_bias_rail_ok = 1'b1;
         enable_in = (p == 1);
         power_input_rail_ok = (p != 1);
         cyc(3);
         chk_bit(soft_start_active, 1'b0);
         enable_in = 1'b1;
         power_input_rail_ok = 1'b1;
         recover(1'b0);
         repeat (3) pulse(p[0]);
         output_overvoltage_cmp = 1'b1;
         cyc(4);
         chk_bit(soft_start_active, 1'b1);
         output_overvoltage_cmp = 1'b0;
         power_stage_die_hot = 1'b1;
         cyc(2);
         chk_bit(high_side_on | low_side_on | soft_start_active, 1'b0);
         power_stage_die_hot = 1'b0;
         recover(1'b0);
         controller_die_hot = 1'b1;
         cyc(2);
         chk_bit(fault_latched, !p[1]);
         controller_die_hot = 1'b0;
         recover(!p[1]);
         power_input_rail_ov = 1'b1;
         cyc(2);
         power_input_rail_ov = 1'b0;
         cyc(4);
         chk_bit(fault_latched, 1'b1);
         recover(1'b1);
         soft_start_done = 1'b1;
         wait_hi(1, 100, n);
         chk_cnt(n, PG, PG + 4);
         output_in_window = 1'b0;
         cyc(2);
         chk_bit(power_good_oe_n, 1'b0);
         output_in_window = 1'b1;
         soft_start_done = 1'b0;
         ov_case(p[1]);
         soft_start_done = 1'b1;
         output_undervoltage_cmp = 1'b1;
         cyc(400);
         output_undervoltage_cmp = 1'b0;
         cyc(1);
         output_undervoltage_cmp = 1'b1;
         cyc(UV - 2);
         chk_bit(power_good_oe_n, 1'b1);
         cyc(5);
         chk_bit(fault_latched, !p[1]);
         output_undervoltage_cmp = 1'b0;
         enable_in = 1'b0;
         cyc(2);
         chk_bit(power_good_oe_n | high_side_on, 1'b0);
      end
      tally_and_finish();
   end
   // Cut a hang short
   initial
   begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule // buck_fault_pgood_sequencer_tb
`default_nettype wire
